// ==== rtl/efc_pkg.sv ====
// Purpose: Shared constants for the fiber converter control block.
// Assumes: 125 MHz pclk, 32-bit APB register bus.
// Notes:   Times are kept in milliseconds and turned into cycle counts here.
`default_nettype none
package efc_pkg;
  localparam int unsigned CLK_KHZ     = 125000;
  localparam int unsigned BLINK_MS    = 250;
  localparam int unsigned ACT_MS      = 50;
  localparam int unsigned BLINK_CYC   = BLINK_MS * CLK_KHZ;
  localparam int unsigned ACT_CYC     = ACT_MS * CLK_KHZ;

  // Register byte offsets.
  localparam logic [7:0] CONFIG_OFF   = 8'h00;
  localparam logic [7:0] STATUS_OFF   = 8'h04;

  // Configuration fields, shared by the switch bank and the CONFIG register.
  localparam int unsigned CFG_FORCE   = 0;
  localparam int unsigned CFG_HALF    = 1;
  localparam int unsigned CFG_TEN     = 2;
  localparam int unsigned CFG_RSVD    = 3;
  localparam int unsigned CFG_RELAY   = 4;
  localparam int unsigned CFG_LONG    = 5;
  localparam int unsigned CFG_W       = 6;
  localparam logic [CFG_W-1:0] CFG_RESET = 6'h00;

  // Status fields above the effective configuration bits.
  localparam int unsigned ST_MANAGED  = 6;
  localparam int unsigned ST_LEGACY   = 7;
  localparam int unsigned ST_FIBER    = 8;
  localparam int unsigned ST_COPPER   = 9;
  localparam int unsigned ST_TX_EN    = 10;

  // Frame length limits in bytes.
  localparam int unsigned LEN_W       = 11;
  localparam logic [LEN_W-1:0] LEN_STD    = 11'h5F2;
  localparam logic [LEN_W-1:0] LEN_VLAN   = 11'h600;
  localparam logic [LEN_W-1:0] LEN_JUMBO  = 11'h640;

  // Synchronised pin vector layout.
  localparam int unsigned PIN_MGMT    = 0;
  localparam int unsigned PIN_MFAULT  = 1;
  localparam int unsigned PIN_LEGACY  = 2;
  localparam int unsigned PIN_BUTTON  = 3;
  localparam int unsigned PIN_FLINK   = 4;
  localparam int unsigned PIN_FFULL   = 5;
  localparam int unsigned PIN_FACT    = 6;
  localparam int unsigned PIN_CLINK   = 7;
  localparam int unsigned PIN_C100    = 8;
  localparam int unsigned PIN_CFULL   = 9;
  localparam int unsigned PIN_CACT    = 10;
  localparam int unsigned PIN_SW      = 11;
  localparam int unsigned PIN_W       = PIN_SW + CFG_W;

  // Strap capture waits this many cycles after reset release.
  localparam logic [1:0] STRAP_WAIT   = 2'h3;
endpackage
`default_nettype wire

// ==== rtl/efc_led.sv ====
// Purpose: One status indicator: steady, dark, or blinking on activity.
// Assumes: act is already synchronous to pclk.
// Notes:   Activity is stretched so a single packet gives a visible blink.
`default_nettype none
module efc_led
  import efc_pkg::*;
#(
  parameter int unsigned HOLD_CYC = ACT_CYC
)
(
  // Clock and reset.
  input  wire logic pclk,
  input  wire logic presetn,
  // Indicator control.
  input  wire logic lit,
  input  wire logic act,
  input  wire logic phase,
  output logic      led_q
);
  logic [31:0] hold_q;

  if (HOLD_CYC < 1)
  begin : g_bad_hold
    $error("efc_led: HOLD_CYC must be at least one");
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hold_q <= 32'h0000_0000;
    else if (act)
      hold_q <= HOLD_CYC[31:0];
    else if (hold_q != 32'h0000_0000)
      hold_q <= hold_q - 32'h0000_0001;
  end

  // A dark indicator stays dark: blinking only modulates a lit one.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      led_q <= 1'b0;
    else
      led_q <= lit & ~((act | (hold_q != 32'h0000_0000)) & phase);
  end
endmodule
`default_nettype wire

// ==== rtl/efc_ctrl.sv ====
// Purpose: Control logic of a copper to fiber Ethernet media converter card.
// Assumes: All pins except APB are asynchronous and pass two flip-flops first.
// Notes:   Settings come from the switch bank, or from CONFIG when managed.
//
// Contract
// - Managed chassis: use management settings, ignore switches; with mgmt_fault set, the switches govern instead
// - Switch 1 off autonegotiates, on forces
// - Forced: switch 2 off full, on half
// - Forced: switch 3 off 100, on 10
// - Switch 5 enables link loss relay
// - Legacy: switch 6 selects 1536 or 1522
// - Current variant: frames up to 1600 always
// - Legacy: push button selects crossover wiring
// - Current variant: automatic crossover, button ignored
// - Relay on, fiber down: copper transmitter off
// - Power lit; blinks without good management
// - Fiber duplex indicator follows fiber duplex
// - Fiber link indicator: link, dark, blink activity
// - Copper speed indicator lit at 100
// - Copper duplex indicator lit at full
// - Copper link indicator: link, dark, blink activity
// - Copper 10/100 port converts to fiber 100
//
// Register access over APB and the register offsets were left to the implementer.
`default_nettype none
module efc_ctrl
  import efc_pkg::*;
#(
  parameter int unsigned BLINK_CYCLES = BLINK_CYC,
  parameter int unsigned ACT_CYCLES   = ACT_CYC
)
(
  // APB slave.
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Chassis and straps.
  input  wire logic        mgmt_present,
  input  wire logic        mgmt_fault,
  input  wire logic        hw_legacy,
  input  wire logic        mdix_button,
  input  wire logic [5:0]  config_switch,
  // Fiber transceiver status.
  input  wire logic        fiber_link,
  input  wire logic        fiber_full,
  input  wire logic        fiber_rx_act,
  // Copper transceiver status.
  input  wire logic        copper_link,
  input  wire logic        copper_speed100,
  input  wire logic        copper_full,
  input  wire logic        copper_rx_act,
  // Copper transceiver control.
  output logic             copper_autoneg_en,
  output logic             copper_force_full,
  output logic             copper_force_100,
  output logic             copper_tx_en,
  output logic             mdix_auto,
  output logic             mdix_cross,
  output logic [10:0]      max_frame_len,
  // Indicators.
  output logic             power_indicator,
  output logic             fiber_full_led,
  output logic             fiber_link_led,
  output logic             copper_speed_led,
  output logic             copper_full_led,
  output logic             copper_link_led
);
  logic [PIN_W-1:0] pin_1q;
  logic [PIN_W-1:0] pin_2q;
  logic [CFG_W-1:0] cfg_q;
  logic [CFG_W-1:0] eff;
  logic [1:0]       strap_cnt_q;
  logic             legacy_q;
  logic             managed;
  logic             relay_en;
  logic [31:0]      blink_cnt_q;
  logic             phase_q;
  logic [31:0]      status;
  logic             setup;
  logic             mapped;
  logic [2:0]       led_lit;
  logic [2:0]       led_act;
  logic [2:0]       led_q;

  if (BLINK_CYCLES < 2 || ACT_CYCLES < 1)
  begin : g_bad_time
    $error("efc_ctrl: blink and activity counts too small");
  end

  // Every pin except APB is reached only through this two-stage synchroniser.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_1q <= '0;
      pin_2q <= '0;
    end
    else
    begin
      pin_1q <= {config_switch, copper_rx_act, copper_full, copper_speed100, copper_link,
                 fiber_rx_act, fiber_full, fiber_link, mdix_button, hw_legacy,
                 mgmt_fault, mgmt_present};
      pin_2q <= pin_1q;
    end
  end

  // The variant strap is caught once, after the synchroniser has filled.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strap_cnt_q <= 2'h0;
      legacy_q    <= 1'b0;
    end
    else if (strap_cnt_q != STRAP_WAIT)
    begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      legacy_q    <= pin_2q[PIN_LEGACY];
    end
  end

  // A faulty management card cannot be trusted, so the switches govern then.
  assign managed  = pin_2q[PIN_MGMT] & ~pin_2q[PIN_MFAULT];
  assign eff      = managed ? cfg_q : pin_2q[PIN_SW +: CFG_W];
  assign relay_en = eff[CFG_RELAY];

  // Copper port mode; speed and duplex only matter when forced.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      copper_autoneg_en <= 1'b1;
      copper_force_full <= 1'b1;
      copper_force_100  <= 1'b1;
    end
    else
    begin
      copper_autoneg_en <= ~eff[CFG_FORCE];
      copper_force_full <= eff[CFG_FORCE] ? ~eff[CFG_HALF] : 1'b1;
      copper_force_100  <= eff[CFG_FORCE] ? ~eff[CFG_TEN] : 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      max_frame_len <= LEN_STD;
    else if (!legacy_q)
      max_frame_len <= LEN_JUMBO;
    else
      max_frame_len <= eff[CFG_LONG] ? LEN_VLAN : LEN_STD;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mdix_auto  <= 1'b0;
      mdix_cross <= 1'b0;
    end
    else
    begin
      mdix_auto  <= ~legacy_q;
      mdix_cross <= legacy_q & pin_2q[PIN_BUTTON];
    end
  end

  // Link loss relay: the copper partner sees its own link drop.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      copper_tx_en <= 1'b1;
    else
      copper_tx_en <= ~relay_en | pin_2q[PIN_FLINK];
  end

  // Shared blink phase so all blinking indicators stay in step.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      blink_cnt_q <= 32'h0000_0000;
      phase_q     <= 1'b0;
    end
    else if (blink_cnt_q == BLINK_CYCLES[31:0] - 32'h0000_0001)
    begin
      blink_cnt_q <= 32'h0000_0000;
      phase_q     <= ~phase_q;
    end
    else
      blink_cnt_q <= blink_cnt_q + 32'h0000_0001;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fiber_full_led   <= 1'b0;
      copper_speed_led <= 1'b0;
      copper_full_led  <= 1'b0;
    end
    else
    begin
      fiber_full_led   <= pin_2q[PIN_FFULL];
      copper_speed_led <= pin_2q[PIN_C100];
      copper_full_led  <= pin_2q[PIN_CFULL];
    end
  end

  // Blinking indicators: power, fiber link, copper link.
  assign led_lit = {pin_2q[PIN_CLINK], pin_2q[PIN_FLINK], 1'b1};
  assign led_act = {pin_2q[PIN_CACT], pin_2q[PIN_FACT], ~managed};

  for (genvar i = 0; i < 3; i++)
  begin : g_led
    efc_led #(
      .HOLD_CYC (ACT_CYCLES)
    ) u_led (
      .pclk    (pclk),
      .presetn (presetn),
      .lit     (led_lit[i]),
      .act     (led_act[i]),
      .phase   (phase_q),
      .led_q   (led_q[i])
    );
  end

  assign power_indicator = led_q[0];
  assign fiber_link_led  = led_q[1];
  assign copper_link_led = led_q[2];

  // APB: one wait state, read data latched in setup, write at completion.
  assign setup  = psel & ~penable;
  assign mapped = (paddr == CONFIG_OFF) || (paddr == STATUS_OFF);
  assign status = {21'h0, copper_tx_en, pin_2q[PIN_CLINK], pin_2q[PIN_FLINK],
                   legacy_q, managed, eff};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      if (setup)
        prdata <= (paddr == CONFIG_OFF) ? {26'h0, cfg_q} :
                  (paddr == STATUS_OFF) ? status : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cfg_q <= CFG_RESET;
    else if (psel && penable && pready && pwrite && paddr == CONFIG_OFF)
      cfg_q <= pwdata[CFG_W-1:0];
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_relay_off;
    relay_en && !pin_2q[PIN_FLINK] |=> !copper_tx_en;
  endproperty
  a_relay_off: assert property (p_relay_off) else $error("tx not off on fiber loss");

  property p_relay_back;
    $rose(pin_2q[PIN_FLINK]) |=> copper_tx_en;
  endproperty
  a_relay_back: assert property (p_relay_back) else $error("tx not back after fiber");

  property p_managed;
    managed && $stable(cfg_q) |=> copper_autoneg_en == !$past(cfg_q[CFG_FORCE]);
  endproperty
  a_managed: assert property (p_managed) else $error("managed setting not used");

  property p_auto;
    !managed && !pin_2q[PIN_SW + CFG_FORCE] |=> copper_autoneg_en && copper_force_full;
  endproperty
  a_auto: assert property (p_auto) else $error("autonegotiation not selected");

  property p_duplex;
    !managed && pin_2q[PIN_SW + CFG_FORCE] |=>
      copper_force_full == !$past(pin_2q[PIN_SW + CFG_HALF]);
  endproperty
  a_duplex: assert property (p_duplex) else $error("forced duplex wrong");

  property p_speed;
    !managed && pin_2q[PIN_SW + CFG_FORCE] |=>
      copper_force_100 == !$past(pin_2q[PIN_SW + CFG_TEN]);
  endproperty
  a_speed: assert property (p_speed) else $error("forced speed wrong");

  property p_legacy_len;
    legacy_q && !managed && !pin_2q[PIN_SW + CFG_LONG] |=> max_frame_len == LEN_STD;
  endproperty
  a_legacy_len: assert property (p_legacy_len) else $error("legacy frame limit wrong");

  property p_jumbo;
    // Only once the strap is caught: before that legacy_q may still change.
    !legacy_q && strap_cnt_q == STRAP_WAIT |=>
      max_frame_len == LEN_JUMBO && mdix_auto && !mdix_cross;
  endproperty
  a_jumbo: assert property (p_jumbo) else $error("current variant settings wrong");

  property p_speed_led;
    ##1 copper_speed_led == $past(pin_2q[PIN_C100]);
  endproperty
  a_speed_led: assert property (p_speed_led) else $error("speed indicator wrong");

  c_managed_write: cover property (psel && penable && pready && pwrite && paddr == CONFIG_OFF);
  c_relay_drop:    cover property (relay_en && $fell(pin_2q[PIN_FLINK]));
  c_forced_ten:    cover property (!managed && pin_2q[PIN_SW + CFG_FORCE] &&
                                   pin_2q[PIN_SW + CFG_TEN]);
  c_power_blink:   cover property ($fell(power_indicator));
endmodule
`default_nettype wire

// ==== verification/efc_peer.sv ====
// Purpose: Remote Ethernet equipment on the copper and fiber links.
// Assumes: Driven from the bench by plain requests, all changes on pclk.
// Notes:   Receive activity is only shown while the matching link is up.
`default_nettype none
module efc_peer
(
  // Clock.
  input  wire logic pclk,
  // Requests from the bench.
  input  wire logic fiber_up,
  input  wire logic fiber_busy,
  input  wire logic copper_busy,
  // Copper transmitter of the converter.
  input  wire logic copper_tx_en,
  // Link status seen by the converter.
  output logic      fiber_link,
  output logic      fiber_rx_act,
  output logic      copper_link,
  output logic      copper_rx_act
);
  timeunit 1ns;
  timeprecision 1ps;

  // The copper partner loses its link when our transmitter goes quiet.
  always_ff @(posedge pclk)
  begin
    fiber_link    <= fiber_up;
    fiber_rx_act  <= fiber_up & fiber_busy;
    copper_link   <= copper_tx_en;
    copper_rx_act <= copper_tx_en & copper_busy;
  end
endmodule
`default_nettype wire

// ==== verification/efc_ctrl_bench.sv ====
// Purpose: Self-checking bench for the converter control block.
// Assumes: Short blink and activity counts; APB answers are awaited, not assumed.
// Notes:   Random switch and status values come from one fixed seed.
`default_nettype none
module efc_ctrl_bench
  import efc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err;
  logic        mgmt_present = 1'b0, mgmt_fault = 1'b0, hw_legacy = 1'b0, mdix_button = 1'b0;
  logic [5:0]  config_switch = 6'h00, hi, lo, cfg;
  logic        fiber_up = 1'b1, fiber_busy = 1'b0, copper_busy = 1'b0;
  logic        fiber_link, fiber_full = 1'b0, fiber_rx_act, copper_link, copper_rx_act;
  logic        copper_speed100 = 1'b0, copper_full = 1'b0;
  logic        copper_autoneg_en, copper_force_full, copper_force_100, copper_tx_en;
  logic        mdix_auto, mdix_cross, power_indicator, fiber_full_led, fiber_link_led;
  logic        copper_speed_led, copper_full_led, copper_link_led;
  logic [10:0] max_frame_len;
  logic [5:0]  leds;
  int          num_errors = 0, compares = 0;

  assign leds = {power_indicator, fiber_full_led, fiber_link_led,
                 copper_speed_led, copper_full_led, copper_link_led};

  efc_ctrl #(.BLINK_CYCLES(8), .ACT_CYCLES(4)) efc_ctrl_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .mgmt_present(mgmt_present),
    .mgmt_fault(mgmt_fault), .hw_legacy(hw_legacy), .mdix_button(mdix_button),
    .config_switch(config_switch), .fiber_link(fiber_link), .fiber_full(fiber_full),
    .fiber_rx_act(fiber_rx_act), .copper_link(copper_link), .copper_speed100(copper_speed100),
    .copper_full(copper_full), .copper_rx_act(copper_rx_act),
    .copper_autoneg_en(copper_autoneg_en), .copper_force_full(copper_force_full),
    .copper_force_100(copper_force_100), .copper_tx_en(copper_tx_en), .mdix_auto(mdix_auto),
    .mdix_cross(mdix_cross), .max_frame_len(max_frame_len),
    .power_indicator(power_indicator), .fiber_full_led(fiber_full_led),
    .fiber_link_led(fiber_link_led), .copper_speed_led(copper_speed_led),
    .copper_full_led(copper_full_led), .copper_link_led(copper_link_led));
  efc_peer efc_peer_inst (.pclk(pclk), .fiber_up(fiber_up), .fiber_busy(fiber_busy),
    .copper_busy(copper_busy), .copper_tx_en(copper_tx_en), .fiber_link(fiber_link),
    .fiber_rx_act(fiber_rx_act), .copper_link(copper_link), .copper_rx_act(copper_rx_act));

  initial
  begin
    forever #4 pclk = ~pclk;
  end

  task automatic end_sim();
    $display("Counts: %0d compares, %0d mismatches", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    compares++;
    if (s !== e)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  // Expected copper control and frame limit for one configuration.
  function automatic logic [13:0] expect_ctl(logic [5:0] c, logic leg);
    logic [10:0] len;
    len = leg ? (c[CFG_LONG] ? LEN_VLAN : LEN_STD) : LEN_JUMBO;
    return {~c[CFG_FORCE], c[CFG_FORCE] ? ~c[CFG_HALF] : 1'b1,
            c[CFG_FORCE] ? ~c[CFG_TEN] : 1'b1, len};
  endfunction

  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // The rising edge that samples pready high completes the transfer.
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      num_errors++;
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic settle();
    repeat (6) @(posedge pclk);
  endtask

  task automatic watch();
    hi = 6'h00; lo = 6'h00;
    repeat (48)
    begin
      @(posedge pclk);
      hi |= leds; lo |= ~leds;
    end
  endtask

  task automatic rst(logic leg);
    presetn <= 1'b0; hw_legacy <= leg;
    repeat (3) @(posedge pclk);
    chk("reset ctl", {3'h7, LEN_STD, 1'b1, 6'h00},
        {copper_autoneg_en, copper_force_full, copper_force_100, max_frame_len,
         copper_tx_en, leds});
    presetn <= 1'b1;
    settle();
  endtask

  task automatic sweep(logic leg);
    logic [5:0] c;
    for (int i = 0; i < 10; i++)
    begin
      c = (i == 0) ? 6'h00 : (i == 1) ? 6'h3F : (i == 2) ? 6'h01 : 6'($urandom);
      c[CFG_RELAY] = 1'b0;
      config_switch <= c; mdix_button <= 1'($urandom);
      fiber_full <= 1'($urandom); copper_full <= 1'($urandom);
      copper_speed100 <= 1'($urandom);
      settle();
      chk("switch ctl", expect_ctl(c, leg), {copper_autoneg_en, copper_force_full,
          copper_force_100, max_frame_len});
      chk("mdix", leg ? {1'b0, mdix_button} : 2'b10, {mdix_auto, mdix_cross});
      chk("mode leds", {fiber_full, copper_speed100, copper_full},
          {fiber_full_led, copper_speed_led, copper_full_led});
      chk("link leds", 2'b11, {fiber_link_led, copper_link_led});
    end
    $display("Test switches done, legacy %0d", leg);
  endtask

  initial
  begin
    void'($urandom(32'hd3d8));
    rst(1'b1);
    sweep(1'b1);
    rst(1'b0);
    sweep(1'b0);
    watch();
    chk("power blinks", 1'b1, hi[5] & lo[5]);
    // Managed: register settings win over opposite switches.
    mgmt_present <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      cfg = (i == 0) ? 6'h3F : 6'($urandom);
      cfg[CFG_RELAY] = 1'b0;
      config_switch <= ~cfg;
      apb(1'b1, CONFIG_OFF, {26'($urandom), cfg});
      settle();
      chk("managed ctl", expect_ctl(cfg, 1'b0), {copper_autoneg_en, copper_force_full,
          copper_force_100, max_frame_len});
      apb(1'b0, CONFIG_OFF, 32'h0);
      chk("config read", {26'h0, cfg}, rd);
      apb(1'b0, STATUS_OFF, 32'h0);
      chk("status", {1'b0, 1'b1, cfg}, rd[7:0]);
    end
    apb(1'b0, 8'h08, 32'h0);
    chk("unmapped data", 32'h0000_0000, rd);
    chk("unmapped error", 1'b1, err);
    watch();
    chk("power steady", 2'b10, {hi[5], lo[5]});
    mgmt_fault <= 1'b1;
    settle();
    chk("fault fallback", expect_ctl(~cfg, 1'b0), {copper_autoneg_en, copper_force_full,
        copper_force_100, max_frame_len});
    mgmt_present <= 1'b0; mgmt_fault <= 1'b0;
    $display("Test management done");
    // Link loss relay on and off.
    for (int r = 1; r >= 0; r--)
    begin
      config_switch <= r ? 6'h10 : 6'h00;
      settle();
      fiber_up <= 1'b0;
      settle();
      chk("tx on fiber loss", r == 0, copper_tx_en);
      chk("copper link", r == 0, copper_link);
      fiber_up <= 1'b1;
      repeat (4) settle();
      chk("tx on fiber back", 1'b1, copper_tx_en);
    end
    $display("Test relay done");
    fiber_busy <= 1'b1; copper_busy <= 1'b1;
    watch();
    chk("activity blink", 2'b11, {hi[3] & lo[3], hi[0] & lo[0]});
    fiber_busy <= 1'b0; copper_busy <= 1'b0;
    $display("Test activity done");
    end_sim();
  end

  initial
  begin
    repeat (100000) @(posedge pclk);
    num_errors++;
    end_sim();
  end
endmodule
`default_nettype wire
